/* pmam_defines.svh */
`ifndef PMAM_DEFINES_SVH
`define PMAM_DEFINES_SVH
`define PMAM_OFS_COUNT_B 8'h48
`define PMAM_OFS_GPI_CTL 8'h4C
`define PMAM_OFS_RES_D 8'h50
`define PMAM_OFS_ACT_A 8'h54
`define PMAM_OFS_ACT_B 8'h58
`define PMAM_OFS_STATUS 8'h5C
`define PMAM_OFS_PMCTL 8'h60
`define PMAM_RST_WORD 32'h0000_0000
`define PMAM_SLICE_CLKS 9'h100
`define PMAM_WINDOW_SLICES 9'h100
`define PMAM_CLK_MHZ 250
`define PMAM_LOCK_US_SLOW 1000
`define PMAM_LOCK_US_FAST 8
`define PMAM_LOCK_CYC_SLOW (`PMAM_LOCK_US_SLOW * `PMAM_CLK_MHZ)
`define PMAM_LOCK_CYC_FAST (`PMAM_LOCK_US_FAST * `PMAM_CLK_MHZ)
`define PMAM_DUTY_PERIOD 8
`endif

/* pmam_pkg.sv */
package pmam_pkg;
	typedef struct packed {
		logic [21:0] gpi;
		logic [7:0] dack;
		logic [15:0] irq;
		logic nmi;
		logic init;
		logic smi_in;
		logic wake;
		logic pwr_btn;
		logic lid;
		logic [3:0] range_hit;
	} pmam_evt_in_t;
	typedef struct packed {
		logic [13:0] monitor_evt;
		logic slow_burst_reload;
		logic fast_burst_reload;
		logic stop_break;
		logic standby_reload;
		logic idle8_reload;
	} pmam_evt_out_t;
	typedef enum logic [2:0] {
		PMAM_RUN = 3'b001,
		PMAM_STOPPED = 3'b010,
		PMAM_LOCK = 3'b100
	} pmam_cpu_state_t;
endpackage

/* pmam_top.sv */
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pmam_defines.svh"
module pmam_top
	import pmam_pkg::*;
#(
	parameter int LOCK_CYC_SLOW = `PMAM_LOCK_CYC_SLOW,
	parameter int LOCK_CYC_FAST = `PMAM_LOCK_CYC_FAST
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire pmam_evt_in_t evt_in,
	input wire logic [15:0] irq_mask,
	input wire logic pci_data_phase,
	input wire logic thermal_alarm_input,
	input wire logic smi_enabled,
	input wire logic clock_control_mode,
	input wire logic cpu_stopped,
	output pmam_evt_out_t evt_out,
	output logic [4:0] fast_burst_load_value,
	output logic fast_burst_lock_mode,
	output logic [4:0] bus_master_idle_load,
	output logic cpu_clock_stop_request,
	output logic cache_sleep_output,
	output logic system_management_interrupt,
	output logic lock_tick
);
	logic rs1_q, rs_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rs1_q <= 1'b0;
			rs_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs_q <= rs1_q;
		end
	end

	// Pin inputs: three stages, change counts when stages 2 and 3 agree
	localparam int PW = $bits(pmam_evt_in_t) + 3;
	logic [PW-1:0] s1_q, s2_q, s3_q, cln_q;
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			cln_q <= '0;
		end else begin
			s1_q <= {evt_in, thermal_alarm_input, clock_control_mode,
				cpu_stopped};
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < PW; i++) begin
				if (s2_q[i] == s3_q[i])
					cln_q[i] <= s3_q[i];
			end
		end
	end
	pmam_evt_in_t ev;
	logic therm_n, ccm, stopped;
	assign {ev, therm_n, ccm, stopped} = cln_q;

	logic [31:0] cntb_q, gp_input_control_q, resd_q, acta_q, actb_q;
	logic video_sts_q;
	logic video_evt;
	logic pmctl_rd;
	logic wait_q;
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[b*8 +: 8] = n[b*8 +: 8];
		return r;
	endfunction

	// One wait state: answer on second edge of a request
	assign pmctl_rd = avs_read && !wait_q &&
		(avs_address == `PMAM_OFS_PMCTL);
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q) begin
			wait_q <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			wait_q <= (avs_read || avs_write) && !wait_q;
			avs_waitrequest <= !((avs_read || avs_write) && !wait_q);
		end
	end

	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q) begin
			cntb_q <= `PMAM_RST_WORD;
			gp_input_control_q <= `PMAM_RST_WORD;
			resd_q <= `PMAM_RST_WORD;
			acta_q <= `PMAM_RST_WORD;
			actb_q <= `PMAM_RST_WORD;
		end else if (avs_write && wait_q) begin
			unique case (avs_address)
				`PMAM_OFS_COUNT_B:
					cntb_q <= merge(cntb_q, avs_writedata, avs_byteenable)
						& 32'h007C_FFFF;
				`PMAM_OFS_GPI_CTL:
					gp_input_control_q <= merge(gp_input_control_q, avs_writedata,
						avs_byteenable) & 32'h0FFF_FFFF;
				`PMAM_OFS_RES_D:
					resd_q <= merge(resd_q, avs_writedata, avs_byteenable)
						& 32'h007F_583F;
				`PMAM_OFS_ACT_A:
					acta_q <= merge(acta_q, avs_writedata, avs_byteenable);
				`PMAM_OFS_ACT_B:
					actb_q <= merge(actb_q, avs_writedata, avs_byteenable)
						& 32'h03FF_FF77;
				default: ;
			endcase
		end
	end

	// Set beats a same-cycle write-one clear
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q)
			video_sts_q <= 1'b0;
		else if (video_evt)
			video_sts_q <= 1'b1;
		else if (avs_write && wait_q && avs_byteenable[0] &&
			avs_address == `PMAM_OFS_STATUS && avs_writedata[0])
			video_sts_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q)
			avs_readdata <= '0;
		else if (avs_read && !wait_q) begin
			unique case (avs_address)
				`PMAM_OFS_COUNT_B: avs_readdata <= cntb_q;
				`PMAM_OFS_GPI_CTL: avs_readdata <= gp_input_control_q;
				`PMAM_OFS_RES_D: avs_readdata <= resd_q;
				`PMAM_OFS_ACT_A: avs_readdata <= acta_q;
				`PMAM_OFS_ACT_B: avs_readdata <= actb_q;
				`PMAM_OFS_STATUS: avs_readdata <= {26'h0, therm_n,
					cpu_clock_stop_request, cache_sleep_output,
					fast_burst_lock_mode, stopped, video_sts_q};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q)
			system_management_interrupt <= 1'b0;
		else
			system_management_interrupt <= pmctl_rd && actb_q[25] &&
				smi_enabled;
	end

	// Fixed input mapping, index = monitor 1..13
	logic [13:1] gpi_raw;
	assign gpi_raw = {ev.gpi[21], ev.gpi[20], ev.gpi[19], ev.gpi[18],
		ev.gpi[4], ev.gpi[17], ev.gpi[16], ev.gpi[15], ev.gpi[14],
		ev.gpi[13], ev.gpi[0], ev.gpi[6], ev.gpi[5]};
	logic [13:1] gpi_act, gpi_prev_q, gpi_evt;
	assign gpi_act = gpi_raw ^ gp_input_control_q[25:13];
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q)
			gpi_prev_q <= '0;
		else
			gpi_prev_q <= gpi_act;
	end
	always_comb begin
		gpi_evt = gpi_act & gp_input_control_q[12:0];
		// Edge or level for 12 and 13
		if (gp_input_control_q[26])
			gpi_evt[12] = gpi_evt[12] && !gpi_prev_q[12];
		if (gp_input_control_q[27])
			gpi_evt[13] = gpi_evt[13] && !gpi_prev_q[13];
	end

	logic [13:0] mon;
	logic dma8;
	always_comb begin
		// Printer ack select, code 11 reserved
		unique case (resd_q[22:21])
			2'b00: dma8 = ev.dack[0];
			2'b01: dma8 = ev.dack[1];
			2'b10: dma8 = ev.dack[3];
			default: dma8 = 1'b0;
		endcase
		mon = {gpi_evt, 1'b0};
		mon[8] = mon[8] | (dma8 & resd_q[17]);
		mon[8] = mon[8] | (ev.range_hit[3] & resd_q[18]);
		mon[7] = mon[7] | (ev.range_hit[2] & resd_q[16]);
		mon[6] = mon[6] | (ev.range_hit[1] & resd_q[14]);
		mon[5] = mon[5] | (ev.range_hit[0] & resd_q[12]);
		mon[5] = mon[5] | (ev.dack[2] & resd_q[11]);
		mon[4] = mon[4] | |({ev.dack[7], ev.dack[6], ev.dack[5],
			ev.dack[3], ev.dack[1], ev.dack[0]} & resd_q[5:0]);
		mon[11] = mon[11] | (ev.irq[12] & resd_q[20]) |
			(ev.irq[1] & resd_q[19]);
		mon[11] = mon[11] | (video_evt & actb_q[24]);
	end

	logic [15:0] irq_on;
	logic irq_grp, brst, slow_r, fast_r, stdby;
	logic [13:0] bmon;
	assign irq_on = ev.irq & ~irq_mask;
	assign irq_grp = |{irq_on[15:9], irq_on[7:3], irq_on[1], ev.nmi,
		ev.init};
	always_comb begin
		bmon = mon & acta_q[27:14];
		slow_r = bmon[5] & !acta_q[31] | bmon[3] & !acta_q[30] |
			bmon[2] & !acta_q[29] | bmon[1] & !acta_q[28];
		fast_r = bmon[5] & acta_q[31] | bmon[3] & acta_q[30] |
			bmon[2] & acta_q[29] | bmon[1] & acta_q[28];
		brst = (irq_on[8] & actb_q[5]) |
			(|{ev.smi_in, ev.wake, ev.pwr_btn, ev.lid} & actb_q[4]) |
			(irq_grp & actb_q[1]) | (irq_on[0] & actb_q[0]);
		stdby = |(mon & acta_q[13:0]) | (irq_grp & actb_q[6]) |
			((ev.irq[1] | ev.irq[12]) & actb_q[2]);
	end

	// One reload per cycle however many sources
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q)
			evt_out <= '0;
		else begin
			evt_out.monitor_evt <= mon;
			evt_out.slow_burst_reload <= slow_r;
			evt_out.fast_burst_reload <= fast_r | brst;
			evt_out.stop_break <= |bmon | brst;
			evt_out.standby_reload <= stdby;
			evt_out.idle8_reload <= mon[8];
		end
	end

	pmam_cpu_state_t cst_q;
	logic [31:0] tick_cnt_q;
	logic [31:0] tick_lim;
	assign tick_lim = cntb_q[5] ? LOCK_CYC_FAST : LOCK_CYC_SLOW;
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q)
			cst_q <= PMAM_RUN;
		else begin
			unique case (cst_q)
				PMAM_RUN: if (stopped) cst_q <= PMAM_STOPPED;
				PMAM_STOPPED: if (!stopped) cst_q <= PMAM_LOCK;
				PMAM_LOCK: if (stopped) cst_q <= PMAM_STOPPED;
					else if (cntb_q[10:6] == 5'h00 ||
					fast_r) cst_q <= PMAM_RUN;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q) begin
			tick_cnt_q <= '0;
			lock_tick <= 1'b0;
		end else if (cst_q != PMAM_LOCK) begin
			tick_cnt_q <= '0;
			lock_tick <= 1'b0;
		end else if (tick_cnt_q >= tick_lim - 32'd1) begin
			tick_cnt_q <= '0;
			lock_tick <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'd1;
			lock_tick <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q) begin
			fast_burst_load_value <= '0;
			fast_burst_lock_mode <= 1'b0;
			bus_master_idle_load <= '0;
		end else begin
			fast_burst_lock_mode <= (cst_q == PMAM_LOCK);
			fast_burst_load_value <= (cst_q == PMAM_LOCK) ?
				cntb_q[10:6] : cntb_q[4:0];
			bus_master_idle_load <= cntb_q[22:18];
		end
	end

	// Duty eighths; code zero leaves clock running
	logic [2:0] duty_ph_q;
	logic eighth_q;
	logic [7:0] div_q;
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q) begin
			div_q <= '0;
			eighth_q <= 1'b0;
			duty_ph_q <= '0;
			cpu_clock_stop_request <= 1'b0;
		end else begin
			div_q <= div_q + 8'd1;
			eighth_q <= (div_q == 8'hFF);
			if (eighth_q)
				duty_ph_q <= duty_ph_q + 3'd1;
			cpu_clock_stop_request <= !therm_n &&
				(duty_ph_q < cntb_q[13:11]);
		end
	end

	// Cache sleep only in clock control and enabled
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q)
			cache_sleep_output <= 1'b0;
		else
			cache_sleep_output <= cntb_q[14] && ccm && stopped &&
				!(|bmon) && !brst;
	end

	logic [8:0] clk_in_slice_q, slices_q;
	logic [8:0] phases_q;
	logic [8:0] counted_q;
	logic slice_end, slice_hit;
	assign slice_end = (clk_in_slice_q == `PMAM_SLICE_CLKS - 9'd1);
	// Last clock of the slice counts too
	assign slice_hit = (phases_q + {8'h00, pci_data_phase}) >
		{1'b0, actb_q[15:8]};
	always_ff @(posedge clk or negedge rs_q) begin
		if (!rs_q) begin
			clk_in_slice_q <= '0;
			phases_q <= '0;
			slices_q <= '0;
			counted_q <= '0;
		end else begin
			clk_in_slice_q <= slice_end ? 9'd0 : clk_in_slice_q + 9'd1;
			if (slice_end)
				phases_q <= '0;
			else if (pci_data_phase)
				phases_q <= phases_q + 9'd1;
			if (slice_end) begin
				if (slices_q == `PMAM_WINDOW_SLICES - 9'd1) begin
					slices_q <= '0;
					counted_q <= '0;
				end else begin
					slices_q <= slices_q + 9'd1;
					counted_q <= counted_q + {8'h00, slice_hit};
				end
			end
		end
	end
	assign video_evt = slice_end &&
		(slices_q == `PMAM_WINDOW_SLICES - 9'd1) &&
		((counted_q + {8'h00, slice_hit}) >= {1'b0, actb_q[23:16]});
endmodule // pmam_top

/* pmam_assertions.sv */
`timescale 1ns/1ps
module pmam_assertions
	import pmam_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic thermal_alarm_input,
	input wire logic smi_enabled,
	input wire logic clock_control_mode,
	input wire logic fast_burst_lock_mode,
	input wire logic [4:0] bus_master_idle_load,
	input wire logic cpu_clock_stop_request,
	input wire logic cache_sleep_output,
	input wire logic system_management_interrupt,
	input wire logic lock_tick
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("no answer one cycle on");
	wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	refused_read_a: assert property (avs_read && avs_waitrequest &&
		avs_address == 8'h70 |=> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	smi_pulse_a: assert property (
		system_management_interrupt |=> !system_management_interrupt)
		else $error("smi longer than a cycle");
	smi_cause_a: assert property (system_management_interrupt |->
		$past(smi_enabled) || $past(smi_enabled, 2))
		else $error("smi while disabled");
	stop_idle_a: assert property (thermal_alarm_input [*8]
		|=> !cpu_clock_stop_request) else $error("stop request unthrottled");
	sleep_idle_a: assert property (!clock_control_mode [*8]
		|=> !cache_sleep_output) else $error("cache sleep outside mode");
	tick_mode_a: assert property (lock_tick |->
		fast_burst_lock_mode || $past(fast_burst_lock_mode))
		else $error("lock tick outside lock");
	tick_gap_a: assert property (lock_tick |=> !lock_tick [*8])
		else $error("lock ticks too close");
	bm_write_a: assert property ($changed(bus_master_idle_load) |->
		$past(avs_write, 2) && $past(avs_address, 2) == 8'h48)
		else $error("bus master count moved alone");
endmodule // pmam_assertions

bind pmam_top pmam_assertions pmam_assertions_inst (.clk, .rst_n,
	.avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
	.thermal_alarm_input, .smi_enabled, .clock_control_mode,
	.fast_burst_lock_mode, .bus_master_idle_load, .cpu_clock_stop_request,
	.cache_sleep_output, .system_management_interrupt, .lock_tick);

/* tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
	$display("BAD %0t got %h exp %h", $time, a, e); end end
module tb_top
	import pmam_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
	logic [3:0] avs_byteenable = 4'hF;
	logic [15:0] irq_mask = 16'h0000;
	logic pci_data_phase = 1'b0, thermal_alarm_input = 1'b1;
	logic smi_enabled = 1'b0, clock_control_mode = 1'b0, cpu_stopped = 1'b0;
	logic avs_waitrequest, fast_burst_lock_mode, cpu_clock_stop_request;
	logic cache_sleep_output, system_management_interrupt, lock_tick;
	logic [4:0] fast_burst_load_value, bus_master_idle_load;
	pmam_evt_in_t evt_in = '0;
	pmam_evt_out_t evt_out;
	logic [31:0] mdl [logic [7:0]];
	logic [7:0] ad [6] = '{8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h70};
	int gmap [13] = '{5, 6, 0, 13, 14, 15, 16, 17, 4, 18, 19, 20, 21};
	int dk [3] = '{0, 1, 3};
	int n_fail = 0, n_tests = 0, n_smi = 0, seed = 32'hA13B, k, m, c, t;
	pmam_top #(.LOCK_CYC_SLOW(50), .LOCK_CYC_FAST(10)) pmam_top_inst (.clk,
		.rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .evt_in, .irq_mask,
		.pci_data_phase, .thermal_alarm_input, .smi_enabled,
		.clock_control_mode, .cpu_stopped, .evt_out, .fast_burst_load_value,
		.fast_burst_lock_mode, .bus_master_idle_load, .cpu_clock_stop_request,
		.cache_sleep_output, .system_management_interrupt, .lock_tick);
	always #2 clk = ~clk;
	always @(posedge clk) pci_data_phase <= 1'($random(seed));
	// Pulse may land inside a bus cycle, so count it here
	always @(posedge clk) if (system_management_interrupt === 1'b1) n_smi++;
	task give_verdict;
		if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	function automatic logic [31:0] msk(input logic [7:0] a);
		case (a)
		8'h48: return 32'h007C_FFFF;
		8'h4C: return 32'h0FFF_FFFF;
		8'h50: return 32'h007F_583F;
		8'h54: return 32'hFFFF_FFFF;
		8'h58: return 32'h03FF_FF77;
		default: return 32'h0000_0000;
		endcase
	endfunction
	function automatic logic pick(input int i);
		case (i)
		14: return evt_out.standby_reload;
		15: return evt_out.stop_break | evt_out.fast_burst_reload;
		16: return evt_out.idle8_reload;
		17: return evt_out.slow_burst_reload;
		18: return evt_out.fast_burst_reload;
		default: return evt_out.monitor_evt[i];
		endcase
	endfunction
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		for (t = 0; t < 50; t++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (t == 50) begin
			n_fail++;
			give_verdict;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (w) mdl[a] = d & msk(a);
	endtask
	task rchk(input logic [7:0] a);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(rd, mdl[a])
	endtask
	task see(input int i, input logic e);
		logic s;
		s = 1'b0;
		repeat (20) begin
			@(posedge clk);
			s = s | pick(i);
		end
		`CHK(s, e)
	endtask
	task tick(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (lock_tick !== 1'b1 && n < 200);
		if (lock_tick !== 1'b1) begin
			n_fail++;
			give_verdict;
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(avs_waitrequest, 1'b1)
		for (k = 0; k < 6; k++) begin
			mdl[ad[k]] = 32'h0000_0000;
			rchk(ad[k]);
		end
		repeat (3) for (k = 0; k < 6; k++) begin
			bus(1'b1, ad[k], $random(seed));
			rchk(ad[k]);
		end
		`CHK(bus_master_idle_load, mdl[8'h48][22:18])
		`CHK(fast_burst_load_value, mdl[8'h48][4:0])
		for (k = 0; k < 5; k++) bus(1'b1, ad[k], 32'h0000_0000);
		for (c = 0; c < 2; c++) begin
			bus(1'b1, 8'h48, 32'h0000_4143 | (c << 5));
			cpu_stopped <= 1'b1;
			clock_control_mode <= 1'b1;
			repeat (10) @(posedge clk);
			`CHK(cache_sleep_output, 1'b1)
			cpu_stopped <= 1'b0;
			clock_control_mode <= 1'b0;
			tick(m);
			tick(m);
			tick(m);
			`CHK(m, c ? 10 : 50)
			`CHK(fast_burst_lock_mode, 1'b1)
			`CHK(fast_burst_load_value, 5'h05)
		end
		for (c = 1; c < 8; c++) begin
			bus(1'b1, 8'h48, c << 11);
			thermal_alarm_input <= 1'b0;
			repeat (40) @(posedge clk);
			m = 0;
			repeat (2048) begin
				@(posedge clk);
				m += cpu_clock_stop_request;
			end
			`CHK(m, c * 256)
			thermal_alarm_input <= 1'b1;
			repeat (20) @(posedge clk);
		end
		bus(1'b1, 8'h4C, 32'h0000_1FFF);
		for (m = 1; m < 14; m++) begin
			evt_in.gpi[gmap[m - 1]] <= 1'b1;
			see(m, 1'b1);
			evt_in.gpi[gmap[m - 1]] <= 1'b0;
			repeat (10) @(posedge clk);
		end
		bus(1'b1, 8'h4C, 32'h0000_2001);
		see(1, 1'b1);
		bus(1'b1, 8'h54, 32'h0000_8000);
		see(17, 1'b1);
		bus(1'b1, 8'h54, 32'h1000_8000);
		see(18, 1'b1);
		see(17, 1'b0);
		bus(1'b1, 8'h54, 32'h0000_0000);
		evt_in.gpi[5] <= 1'b1;
		repeat (10) @(posedge clk);
		see(1, 1'b0);
		bus(1'b1, 8'h4C, 32'h0000_0000);
		see(1, 1'b0);
		evt_in.gpi[5] <= 1'b0;
		bus(1'b1, 8'h50, 32'h0000_0020);
		for (c = 0; c < 2; c++) begin
			bus(1'b1, 8'h54, c << 4);
			evt_in.dack[7] <= 1'b1;
			see(14, c[0]);
			see(4, 1'b1);
			evt_in.dack[7] <= 1'b0;
			repeat (10) @(posedge clk);
		end
		for (c = 0; c < 3; c++) begin
			bus(1'b1, 8'h50, 32'h0002_0000 | (c << 21));
			evt_in.dack[dk[c]] <= 1'b1;
			see(16, 1'b1);
			evt_in.dack[dk[c]] <= 1'b0;
			repeat (10) @(posedge clk);
		end
		bus(1'b1, 8'h58, 32'h0000_0002);
		for (c = 0; c < 2; c++) begin
			irq_mask <= c ? 16'h0008 : 16'h0000;
			evt_in.irq[3] <= 1'b1;
			see(15, !c[0]);
			evt_in.irq[3] <= 1'b0;
			repeat (10) @(posedge clk);
		end
		bus(1'b1, 8'h58, 32'h0200_0000);
		for (c = 0; c < 2; c++) begin
			smi_enabled <= c[0];
			k = n_smi;
			bus(1'b0, 8'h60, 32'h0000_0000);
			repeat (5) @(posedge clk);
			`CHK(n_smi - k, c)
		end
		give_verdict;
	end
endmodule // tb_top
